// file: cmo_pkg.sv
/*
 * cmo_pkg: shared constants and types of the cache maintenance
 * operation decoder (function codes, organisation, set/way layout).
 * Assumes: compiled before every other file of the block.
 */
package cmo_pkg;

    // =====
    // secondary register numbers of the maintenance register
    // =====
    localparam logic [3:0] CRM_WFI = 4'h0;
    localparam logic [3:0] CRM_ICACHE = 4'h5;
    localparam logic [3:0] CRM_DCACHE = 4'h6;
    localparam logic [3:0] CRM_BOTH = 4'h7;
    localparam logic [3:0] CRM_DCLEAN = 4'hA;
    localparam logic [3:0] CRM_UCLEAN = 4'hB;
    localparam logic [3:0] CRM_IPREF = 4'hD;
    localparam logic [3:0] CRM_DCLINV = 4'hE;
    localparam logic [3:0] CRM_UCLINV = 4'hF;

    // =====
    // function opcode field values
    // =====
    localparam logic [2:0] OPC_ALL = 3'h0;
    localparam logic [2:0] OPC_ADDR = 3'h1;
    localparam logic [2:0] OPC_SW = 3'h2;
    localparam logic [2:0] OPC_TEST = 3'h3;
    localparam logic [2:0] OPC_SPECIAL = 3'h4;
    localparam logic [2:0] OPC_DMB = 3'h5;
    localparam logic [2:0] OPC_BTC_ALL = 3'h6;
    localparam logic [2:0] OPC_BTC_ENT = 3'h7;

    // =====
    // cache organisation of this device
    // =====
    localparam logic UNIFIED = 1'b0;
    localparam logic LOCK_FORMAT_C = 1'b1;
    localparam logic HAS_TEST_CLEAN = 1'b0;

    // =====
    // set/way word layout: log2 line bytes, ways, sets
    // =====
    localparam int SW_L = 5;
    localparam int SW_A = 2;
    localparam int SW_S = 7;
    localparam int SW_TC_BIT = 0;
    localparam int SW_WAY_MSB = 31;

    // return link offset from the waiting instruction
    localparam logic [31:0] RET_LINK_OFS = 32'h0000_0008;

    // =====
    // target selection bits
    // =====
    localparam logic [3:0] SEL_I = 4'h1;
    localparam logic [3:0] SEL_D = 4'h2;
    localparam logic [3:0] SEL_U = 4'h4;
    localparam logic [3:0] SEL_B = 4'h8;
    localparam logic [3:0] SEL_NONE = 4'h0;

    typedef enum logic [3:0] {
        K_NOP = 4'h0,
        K_INV = 4'h1,
        K_CLEAN = 4'h2,
        K_CLINV = 4'h3,
        K_PREF = 4'h4,
        K_WFI = 4'h5,
        K_PFF = 4'h6,
        K_DSB = 4'h7,
        K_DMB = 4'h8
    } cmo_kind_t;

    typedef enum logic [1:0] {
        SC_ALL = 2'h0,
        SC_ADDR = 2'h1,
        SC_SW = 2'h2
    } cmo_scope_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_XLAT = 5'h02,
        ST_CACHE = 5'h04,
        ST_SYNC = 5'h08,
        ST_WFI = 5'h10
    } cmo_state_t;

endpackage

// file: cmo_dec_if.sv
/*
 * cmo_dec_if: carries a function selector to the decoder and the
 * decoded function back to the controller.
 * Assumes: both ends sit in the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
interface cmo_dec_if;
    import cmo_pkg::*;
    logic [3:0] crm;
    logic [2:0] opc;
    logic user_ok;
    cmo_kind_t kind;
    logic [3:0] sel;
    cmo_scope_t scope;
    modport dec (input crm, opc, output user_ok, kind, sel, scope);
    modport ctl (output crm, opc, input user_ok, kind, sel, scope);
endinterface
`default_nettype wire

// file: cmo_decode.sv
/*
 * cmo_decode: purely combinational decode of secondary register and
 * opcode into kind, targets and operand scope.
 * Assumes: driven by the controller through cmo_dec_if.
 */
`timescale 1ns/10ps
`default_nettype none
module cmo_decode
    import cmo_pkg::*;
(
    cmo_dec_if.dec d
);
    // =====
    // organisation masks: foreign-organisation functions hit nothing
    // =====
    localparam logic [3:0] I_SEP = UNIFIED ? SEL_NONE : SEL_I;
    localparam logic [3:0] D_SEP = UNIFIED ? SEL_NONE : SEL_D;
    localparam logic [3:0] U_ONLY = UNIFIED ? SEL_U : SEL_NONE;
    localparam logic [3:0] ALL_C = UNIFIED ? SEL_U : (SEL_I | SEL_D);

    // scope follows the opcode for the whole/line function families
    function automatic cmo_scope_t scope_of(input logic [2:0] o);
        scope_of = (o == OPC_ADDR) ? SC_ADDR :
                   (o == OPC_SW) ? SC_SW : SC_ALL;
    endfunction

    // table of listed functions
    always_comb begin
        d.kind = K_NOP;
        d.sel = SEL_NONE;
        d.scope = scope_of(d.opc);
        d.user_ok = 1'b0;
        case ({d.crm, d.opc})
            {CRM_WFI, OPC_SPECIAL}: d.kind = K_WFI;
            {CRM_ICACHE, OPC_ALL}: begin
                d.kind = K_INV;
                d.sel = I_SEP | SEL_B;
            end
            {CRM_ICACHE, OPC_ADDR}, {CRM_ICACHE, OPC_SW}: begin
                d.kind = K_INV;
                d.sel = I_SEP;
            end
            {CRM_ICACHE, OPC_SPECIAL}: begin
                d.kind = K_PFF;
                d.user_ok = 1'b1;
            end
            {CRM_ICACHE, OPC_BTC_ALL}: begin
                d.kind = K_INV;
                d.sel = SEL_B;
                d.scope = SC_ALL;
            end
            {CRM_ICACHE, OPC_BTC_ENT}: begin
                d.kind = K_INV;
                d.sel = SEL_B;
                d.scope = SC_ADDR;
            end
            {CRM_DCACHE, OPC_ALL}, {CRM_DCACHE, OPC_ADDR},
            {CRM_DCACHE, OPC_SW}: begin
                d.kind = K_INV;
                d.sel = D_SEP;
            end
            {CRM_BOTH, OPC_ALL}: begin
                d.kind = K_INV;
                d.sel = ALL_C | SEL_B;
            end
            {CRM_BOTH, OPC_ADDR}, {CRM_BOTH, OPC_SW}: begin
                d.kind = K_INV;
                d.sel = U_ONLY;
            end
            {CRM_DCLEAN, OPC_ALL}, {CRM_DCLEAN, OPC_ADDR},
            {CRM_DCLEAN, OPC_SW}: begin
                d.kind = K_CLEAN;
                d.sel = D_SEP;
            end
            {CRM_UCLEAN, OPC_ALL}, {CRM_UCLEAN, OPC_ADDR},
            {CRM_UCLEAN, OPC_SW}: begin
                d.kind = K_CLEAN;
                d.sel = U_ONLY;
            end
            {CRM_DCLEAN, OPC_TEST}: begin
                d.kind = HAS_TEST_CLEAN ? K_CLEAN : K_NOP;
                d.sel = HAS_TEST_CLEAN ? D_SEP : SEL_NONE;
            end
            {CRM_DCLEAN, OPC_SPECIAL}: begin
                d.kind = K_DSB;
                d.user_ok = 1'b1;
            end
            {CRM_DCLEAN, OPC_DMB}: begin
                d.kind = K_DMB;
                d.user_ok = 1'b1;
            end
            {CRM_IPREF, OPC_ADDR}: begin
                d.kind = LOCK_FORMAT_C ? K_PREF : K_NOP;
                d.sel = LOCK_FORMAT_C ? (UNIFIED ? SEL_U : SEL_I) : SEL_NONE;
                d.scope = SC_ADDR;
            end
            {CRM_DCLINV, OPC_ALL}, {CRM_DCLINV, OPC_ADDR},
            {CRM_DCLINV, OPC_SW}: begin
                d.kind = K_CLINV;
                d.sel = D_SEP;
            end
            {CRM_DCLINV, OPC_TEST}: begin
                d.kind = HAS_TEST_CLEAN ? K_CLINV : K_NOP;
                d.sel = HAS_TEST_CLEAN ? D_SEP : SEL_NONE;
            end
            {CRM_UCLINV, OPC_ALL}, {CRM_UCLINV, OPC_ADDR},
            {CRM_UCLINV, OPC_SW}: begin
                d.kind = K_CLINV;
                d.sel = U_ONLY;
            end
            default: d.kind = K_NOP; // unlisted pair, no effect
        endcase
    end
endmodule
`default_nettype wire

// file: cmo_ctrl.sv
/*
 * cmo_ctrl: top of the cache maintenance operation decoder. Takes
 * writes to the write-only maintenance register from the core and
 * drives the caches, translation, barrier and wait logic.
 * Assumes: core-side inputs are on CLK; IRQ_LINE, FIQ_LINE and
 * DBG_REQ are asynchronous pins; caches answer with CACHE_DONE.
 */
// Behaviour
// - maintenance register is write-only; crm and opcode pick the function.
// - privileged functions from user mode raise undefined; some allowed.
// - clean writes dirty write-back line data to memory, then marks clean.
// - invalidate marks targets invalid, no cleaning unless also asked.
// - invalidation reaches every targeted line, locked lines too.
// - instruction line prefetch loads cacheably; an abort makes no access.
// - prefetch-instruction-line exists when lock-down is format C.
// - wait-for-interrupt sleeps; any interrupt or enabled debug wakes.
// - masked wake continues; else handler entered with link address+8.
// - prefetch-buffer flush discards prefetched instructions for refetch.
// - address functions look up unaligned addresses; misses do nothing.
// - relocated addresses are used as given, combined with the ADDRESS_SPACE_IDENTIFIER.
// - set/way word decodes set, way and target-select bit.
// - crm 5 decodes instruction cache and branch target functions.
// - crm 6 decodes data cache invalidations.
// - crm 7 decodes whole and unified invalidations.
// - crm 10 and 11 decode clean functions.
// - crm 14 and 15 decode clean-and-invalidate functions.
// - test-and-clean at opcode 3 is optional.
// - crm 10 opcode 4 is sync barrier, opcode 5 order barrier.
// - functions foreign to the organisation complete with no effect.
`timescale 1ns/10ps
`default_nettype none
module cmo_ctrl
    import cmo_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    // maintenance register write from the core
    input wire logic OP_VALID,
    input wire logic [3:0] OP_CRM,
    input wire logic [2:0] OP_OPC,
    input wire logic [31:0] OP_DATA,
    input wire logic [31:0] OP_PC,
    input wire logic OP_USER,
    input wire logic [7:0] OP_ADDRESS_SPACE_IDENTIFIER,
    output logic OP_READY,
    output logic OP_DONE,
    output logic OP_UNDEF,
    // cache maintenance command
    output logic CACHE_REQ,
    output logic [3:0] CACHE_KIND,
    output logic [3:0] CACHE_SEL,
    output logic [1:0] CACHE_SCOPE,
    output logic [31:0] CACHE_ADDR,
    output logic [7:0] CACHE_ADDRESS_SPACE_IDENTIFIER,
    output logic [SW_S-1:0] CACHE_SET,
    output logic [SW_A-1:0] CACHE_WAY,
    output logic CACHE_TCM,
    output logic CACHE_IGN_LOCK,
    output logic CACHE_CACHEABLE,
    input wire logic CACHE_DONE,
    // translation check before a prefetch
    output logic XLAT_REQ,
    input wire logic XLAT_DONE,
    input wire logic XLAT_ABORT,
    // barriers and prefetch buffer
    output logic SYNC_REQ,
    input wire logic SYNC_ACK,
    output logic ORDER_BARRIER,
    output logic PF_FLUSH,
    // wait for interrupt
    input wire logic IRQ_LINE,
    input wire logic FIQ_LINE,
    input wire logic DBG_REQ,
    input wire logic DBG_EN,
    input wire logic IRQ_MASK,
    input wire logic FIQ_MASK,
    output logic LOW_POWER,
    output logic EXC_TAKE,
    output logic EXC_FIQ,
    output logic [31:0] EXC_LINK
);

    // =====
    // state
    // =====
    typedef struct packed {
        cmo_state_t st;
        logic [1:0] irq_s;
        logic [1:0] fiq_s;
        logic [1:0] dbg_s;
        cmo_kind_t kind;
        logic [3:0] sel;
        cmo_scope_t scope;
        logic [31:0] data;
        logic [31:0] pc;
        logic [7:0] address_space_identifier;
        logic done;
        logic undef;
        logic pff;
        logic memory_order_barrier;
        logic take;
        logic take_fiq;
        logic [31:0] link;
    } cmo_regs_t;

    cmo_regs_t r_q;
    cmo_regs_t r_d;
    logic wake;
    logic irq_live;
    logic fiq_live;

    // =====
    // decoder
    // =====
    cmo_dec_if dec_bus ();

    // selector comes straight from the write port
    assign dec_bus.crm = OP_CRM;
    assign dec_bus.opc = OP_OPC;

    cmo_decode u_dec (
        .d(dec_bus)
    );

    // =====
    // wake sources
    // =====
    // the second stage of each pin synchroniser feeds the wake logic
    assign irq_live = r_q.irq_s[1];
    assign fiq_live = r_q.fiq_s[1];
    // masking is ignored for wake; debug needs enable
    assign wake = irq_live | fiq_live | (r_q.dbg_s[1] & DBG_EN);

    // =====
    // next state
    // =====
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.undef = 1'b0;
        r_d.pff = 1'b0;
        r_d.memory_order_barrier = 1'b0;
        r_d.take = 1'b0;
        // two-flop synchronisers for the pins
        r_d.irq_s = {r_q.irq_s[0], IRQ_LINE};
        r_d.fiq_s = {r_q.fiq_s[0], FIQ_LINE};
        r_d.dbg_s = {r_q.dbg_s[0], DBG_REQ};
        case (r_q.st)
            ST_IDLE: begin
                if (OP_VALID) begin
                    // operand and context held for the whole function
                    r_d.data = OP_DATA;
                    r_d.pc = OP_PC;
                    r_d.address_space_identifier = OP_ADDRESS_SPACE_IDENTIFIER;
                    r_d.kind = dec_bus.kind;
                    r_d.sel = dec_bus.sel;
                    r_d.scope = dec_bus.scope;
                    if (OP_USER && !dec_bus.user_ok) begin
                        r_d.undef = 1'b1;
                    end else begin
                        case (dec_bus.kind)
                            K_INV, K_CLEAN, K_CLINV: begin
                                if (dec_bus.sel != SEL_NONE) begin
                                    r_d.st = ST_CACHE;
                                end else begin
                                    r_d.done = 1'b1;
                                end
                            end
                            K_PREF: begin
                                r_d.st = ST_XLAT;
                            end
                            K_WFI: begin
                                r_d.st = ST_WFI;
                            end
                            K_PFF: begin
                                r_d.pff = 1'b1;
                                r_d.done = 1'b1;
                            end
                            K_DSB: begin
                                r_d.st = ST_SYNC;
                            end
                            K_DMB: begin
                                r_d.memory_order_barrier = 1'b1;
                                r_d.done = 1'b1;
                            end
                            default: begin
                                r_d.done = 1'b1;
                            end
                        endcase
                    end
                end
            end
            ST_XLAT: begin
                if (XLAT_DONE) begin
                    if (XLAT_ABORT) begin
                        // aborted prefetch ends with no memory access
                        r_d.st = ST_IDLE;
                        r_d.done = 1'b1;
                    end else begin
                        r_d.st = ST_CACHE;
                    end
                end
            end
            ST_CACHE: begin
                if (CACHE_DONE) begin
                    r_d.st = ST_IDLE;
                    r_d.done = 1'b1;
                end
            end
            ST_SYNC: begin
                if (SYNC_ACK) begin
                    r_d.st = ST_IDLE;
                    r_d.done = 1'b1;
                end
            end
            ST_WFI: begin
                if (wake) begin
                    r_d.st = ST_IDLE;
                    r_d.link = 32'(r_q.pc + RET_LINK_OFS);
                    if (fiq_live && !FIQ_MASK) begin
                        r_d.take = 1'b1;
                        r_d.take_fiq = 1'b1;
                    end else if (irq_live && !IRQ_MASK) begin
                        r_d.take = 1'b1;
                        r_d.take_fiq = 1'b0;
                    end else begin
                        r_d.done = 1'b1;
                    end
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase
    end

    // =====
    // state register
    // =====
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    // =====
    // core side
    // =====
    assign OP_READY = (r_q.st == ST_IDLE);
    assign OP_DONE = r_q.done;
    assign OP_UNDEF = r_q.undef;
    assign EXC_TAKE = r_q.take;
    assign EXC_FIQ = r_q.take_fiq;
    assign EXC_LINK = r_q.link;
    assign PF_FLUSH = r_q.pff;
    assign ORDER_BARRIER = r_q.memory_order_barrier;
    assign LOW_POWER = (r_q.st == ST_WFI);

    // =====
    // cache command, held stable until CACHE_DONE
    // =====
    assign CACHE_REQ = (r_q.st == ST_CACHE);
    assign CACHE_KIND = r_q.kind;
    assign CACHE_SEL = r_q.sel;
    assign CACHE_SCOPE = r_q.scope;
    // unaligned address passed on as is; the cache does the lookup
    assign CACHE_ADDR = r_q.data;
    assign CACHE_ADDRESS_SPACE_IDENTIFIER = r_q.address_space_identifier;
    // set/way fields of the held operand
    assign CACHE_SET = r_q.data[SW_L +: SW_S];
    assign CACHE_WAY = r_q.data[SW_WAY_MSB -: SW_A];
    assign CACHE_TCM = r_q.data[SW_TC_BIT];
    // invalidation also hits locked-down lines
    assign CACHE_IGN_LOCK = (r_q.kind == K_INV) ||
                            (r_q.kind == K_CLINV);
    assign CACHE_CACHEABLE = (r_q.kind == K_PREF);

    // =====
    // translation and barrier requests
    // =====
    assign XLAT_REQ = (r_q.st == ST_XLAT);
    assign SYNC_REQ = (r_q.st == ST_SYNC);

endmodule
`default_nettype wire

// file: cmo_chk.sv
/*
 * cmo_chk: concurrent checks on the maintenance decoder ports.
 * Assumes: bound to every cmo_ctrl, one clock, sync reset.
 */
`timescale 1ns/10ps
`default_nettype none
module cmo_chk
    import cmo_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic OP_VALID,
    input wire logic [3:0] OP_CRM,
    input wire logic [2:0] OP_OPC,
    input wire logic [31:0] OP_DATA,
    input wire logic [31:0] OP_PC,
    input wire logic OP_USER,
    input wire logic OP_READY,
    input wire logic OP_DONE,
    input wire logic OP_UNDEF,
    input wire logic CACHE_REQ,
    input wire logic [3:0] CACHE_KIND,
    input wire logic [3:0] CACHE_SEL,
    input wire logic [31:0] CACHE_ADDR,
    input wire logic CACHE_IGN_LOCK,
    input wire logic CACHE_DONE,
    input wire logic XLAT_REQ,
    input wire logic XLAT_DONE,
    input wire logic XLAT_ABORT,
    input wire logic PF_FLUSH,
    input wire logic LOW_POWER,
    input wire logic EXC_TAKE,
    input wire logic [31:0] EXC_LINK
);
    logic tk;
    logic uok;
    logic [31:0] pc_q;
    // =====
    // helper logic
    // =====
    // a write taken, and the functions open to user mode
    assign tk = OP_VALID && OP_READY;
    assign uok = (OP_CRM == CRM_ICACHE && OP_OPC == OPC_SPECIAL) ||
        (OP_CRM == CRM_DCLEAN && (OP_OPC == OPC_SPECIAL || OP_OPC == OPC_DMB));
    // address of the last wait instruction taken
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pc_q <= '0;
        end else if (tk && OP_CRM == CRM_WFI && OP_OPC == OPC_SPECIAL) begin
            pc_q <= OP_PC;
        end
    end
    // =====
    // properties
    // =====
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_priv(c, o);
        tk && !OP_USER && OP_CRM == c && OP_OPC == o;
    endsequence
    take_answer_a: assert property (tk |=> !OP_READY || OP_DONE || OP_UNDEF)
        else $error("taken write not answered");
    user_undef_a: assert property (tk && OP_USER && !uok |=> OP_UNDEF && !CACHE_REQ)
        else $error("user write of privileged function accepted");
    user_ok_a: assert property (tk && OP_USER && uok |=> !OP_UNDEF)
        else $error("user function refused");
    clean_cmd_a: assert property (s_priv(CRM_DCLEAN, OPC_ADDR) |=> CACHE_REQ &&
        CACHE_KIND == K_CLEAN && CACHE_SEL == SEL_D && CACHE_ADDR == $past(OP_DATA))
        else $error("clean line command wrong");
    inv_lock_a: assert property (CACHE_REQ && CACHE_KIND inside {K_INV, K_CLINV} |->
        CACHE_IGN_LOCK) else $error("invalidate spares locked lines");
    cmd_hold_a: assert property (CACHE_REQ && !CACHE_DONE |=> CACHE_REQ &&
        $stable(CACHE_ADDR) && $stable(CACHE_KIND)) else $error("command not held");
    cmd_done_a: assert property (CACHE_REQ && CACHE_DONE |=> !CACHE_REQ && OP_DONE)
        else $error("cache completion not passed on");
    abort_quiet_a: assert property (XLAT_REQ && XLAT_DONE && XLAT_ABORT |=>
        OP_DONE ##1 !CACHE_REQ [*2]) else $error("aborted prefetch reached cache");
    pf_flush_a: assert property (tk && OP_CRM == CRM_ICACHE && OP_OPC == OPC_SPECIAL
        |=> PF_FLUSH && OP_DONE) else $error("prefetch flush missing");
    sleep_a: assert property (s_priv(CRM_WFI, OPC_SPECIAL) |=> LOW_POWER && !OP_READY)
        else $error("wait did not sleep");
    link_a: assert property (EXC_TAKE |-> EXC_LINK == pc_q + RET_LINK_OFS && !LOW_POWER)
        else $error("return link wrong");
endmodule
bind cmo_ctrl cmo_chk u_chk (.*);
`default_nettype wire

// file: cmo_far_model.sv
/*
 * cmo_far_model: caches, translation and barrier unit answering the
 * decoder after a set number of cycles; a prefetch may abort.
 * Assumes: DLY and ABORT only change between functions.
 */
`timescale 1ns/10ps
`default_nettype none
module cmo_far_model (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [3:0] DLY,
    input wire logic ABORT,
    input wire logic CACHE_REQ,
    input wire logic XLAT_REQ,
    input wire logic SYNC_REQ,
    output logic CACHE_DONE,
    output logic XLAT_DONE,
    output logic XLAT_ABORT,
    output logic SYNC_ACK
);
    logic [3:0] n_q;
    logic busy;
    logic go;
    // answer once the wait count reaches DLY
    assign busy = CACHE_REQ || XLAT_REQ || SYNC_REQ;
    assign go = busy && n_q == DLY;
    always_ff @(posedge CLK) begin
        if (!RESET_N || !busy || go) begin
            n_q <= '0;
        end else begin
            n_q <= n_q + 4'h1;
        end
    end
    // answers; abort shows its inverse outside a done cycle
    assign CACHE_DONE = CACHE_REQ && go;
    assign XLAT_DONE = XLAT_REQ && go;
    assign XLAT_ABORT = go ? ABORT : ~ABORT;
    assign SYNC_ACK = SYNC_REQ && go;
endmodule
`default_nettype wire

// file: tb_top.sv
/*
 * tb_top: drives maintenance writes into cmo_ctrl and checks commands.
 * Assumes: cmo_far_model answers the cache side, cmo_chk is bound.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import cmo_pkg::*;
;
    logic CLK, RESET_N, OP_VALID, OP_USER, OP_READY, OP_DONE, OP_UNDEF;
    logic CACHE_REQ, CACHE_TCM, CACHE_IGN_LOCK, CACHE_CACHEABLE, CACHE_DONE;
    logic XLAT_REQ, XLAT_DONE, XLAT_ABORT, SYNC_REQ, SYNC_ACK, ABORT;
    logic ORDER_BARRIER, PF_FLUSH, IRQ_LINE, FIQ_LINE, DBG_REQ, DBG_EN;
    logic IRQ_MASK, FIQ_MASK, LOW_POWER, EXC_TAKE, EXC_FIQ;
    logic [3:0] OP_CRM, CACHE_KIND, CACHE_SEL, DLY, ck, cs;
    logic [2:0] OP_OPC;
    logic [1:0] CACHE_SCOPE, csc;
    logic [31:0] OP_DATA, OP_PC, CACHE_ADDR, EXC_LINK, ca, lnk;
    logic [7:0] OP_ADDRESS_SPACE_IDENTIFIER, CACHE_ADDRESS_SPACE_IDENTIFIER, cas;
    logic [SW_S-1:0] CACHE_SET, cset;
    logic [SW_A-1:0] CACHE_WAY, cw;
    logic ct, cl, cc;
    logic [4:0] res;
    int ncmd, nsync, n_fail, checked;
    cmo_ctrl uut (.*);
    cmo_far_model far (.*);
    // =====
    // clock, monitor and helpers
    // =====
    always #2 CLK = ~CLK;
    // capture each completed command mid-cycle, away from the edge
    always @(negedge CLK) begin
        if (CACHE_REQ && CACHE_DONE) begin
            ncmd++;
            {ck, cs, csc, ca, cas} = {CACHE_KIND, CACHE_SEL, CACHE_SCOPE, CACHE_ADDR, CACHE_ADDRESS_SPACE_IDENTIFIER};
            {cset, cw, ct, cl, cc} = {CACHE_SET, CACHE_WAY, CACHE_TCM, CACHE_IGN_LOCK, CACHE_CACHEABLE};
        end
        if (SYNC_REQ && SYNC_ACK) nsync++;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one maintenance write; res holds the answer cycle's pulses
    task automatic wr(input logic [3:0] c, input logic [2:0] o, input logic u);
        int k;
        logic rdy;
        {OP_CRM, OP_OPC, OP_USER, OP_VALID} = {c, o, u, 1'b1};
        // ready read while settled, before the edge that takes the write
        for (k = 0; k < 20; k++) begin
            rdy = OP_READY;
            @(posedge CLK);
            if (rdy) break;
        end
        #1 OP_VALID = 1'b0;
        for (k = 0; k < 60 && !(OP_DONE || OP_UNDEF || EXC_TAKE); k++) begin
            @(posedge CLK);
            #1;
        end
        if (k == 60) chk("answer", 1, 0);
        res = {EXC_TAKE, ORDER_BARRIER, PF_FLUSH, OP_UNDEF, OP_DONE};
        lnk = EXC_LINK;
    endtask
    // privileged write and the cache command it must produce
    task automatic t(input logic [3:0] c, input logic [2:0] o, input logic [3:0] k,
            input logic [3:0] s, input logic [1:0] sc);
        int n0;
        n0 = ncmd;
        wr(c, o, 1'b0);
        chk("done", 1, res[0]);
        chk("cmds", n0 + (k != K_NOP), ncmd);
        if (k != K_NOP) begin
            chk("kind", k, ck);
            chk("sel", s, cs);
            chk("scope", sc, csc);
            chk("addr", OP_DATA, ca);
            chk("address_space_identifier", OP_ADDRESS_SPACE_IDENTIFIER, cas);
            chk("set", (OP_DATA >> SW_L) % (1 << SW_S), cset);
            chk("way", OP_DATA >> (SW_WAY_MSB + 1 - SW_A), cw);
            chk("tcm", OP_DATA[SW_TC_BIT], ct);
            chk("lock", k == K_INV || k == K_CLINV, cl);
            chk("cachable", k == K_PREF, cc);
        end
    endtask
    // wait function woken by a pin raised during the sleep
    task automatic sleep(ref logic pin);
        fork
            wr(CRM_WFI, OPC_SPECIAL, 1'b0);
            begin
                wait (LOW_POWER);
                repeat (3) @(posedge CLK);
                #1 pin = 1'b1;
            end
        join
        pin = 1'b0;
        repeat (4) @(posedge CLK);
        #1;
    endtask
    // =====
    // tests
    // =====
    initial begin
        {CLK, RESET_N, OP_VALID, OP_CRM, OP_OPC, OP_USER, ABORT, DLY} = '0;
        {IRQ_LINE, FIQ_LINE, DBG_REQ, DBG_EN, IRQ_MASK, FIQ_MASK} = 6'h01;
        {OP_DATA, OP_PC, OP_ADDRESS_SPACE_IDENTIFIER} = {32'hC000_0A47, 32'h0000_2000, 8'h5A};
        repeat (16) @(posedge CLK);
        #1 RESET_N = 1'b1;
        @(posedge CLK);
        #1;
        for (int p = 0; p < 2; p++) begin
            DLY = p ? 4'h3 : 4'h0;
            t(CRM_ICACHE, OPC_ALL, K_INV, SEL_I | SEL_B, SC_ALL);
            t(CRM_ICACHE, OPC_ADDR, K_INV, SEL_I, SC_ADDR);
            t(CRM_ICACHE, OPC_SW, K_INV, SEL_I, SC_SW);
            t(CRM_ICACHE, OPC_BTC_ALL, K_INV, SEL_B, SC_ALL);
            t(CRM_ICACHE, OPC_BTC_ENT, K_INV, SEL_B, SC_ADDR);
            t(CRM_BOTH, OPC_ALL, K_INV, SEL_I | SEL_D | SEL_B, SC_ALL);
            for (int j = 0; j < 3; j++) begin
                t(CRM_DCACHE, 3'(j), K_INV, SEL_D, 2'(j));
                t(CRM_DCLEAN, 3'(j), K_CLEAN, SEL_D, 2'(j));
                t(CRM_DCLINV, 3'(j), K_CLINV, SEL_D, 2'(j));
                t(CRM_UCLEAN, 3'(j), K_NOP, SEL_NONE, 2'h0);
                t(CRM_UCLINV, 3'(j), K_NOP, SEL_NONE, 2'h0);
                if (j > 0) t(CRM_BOTH, 3'(j), K_NOP, SEL_NONE, 2'h0);
            end
            t(CRM_DCLEAN, OPC_TEST, K_NOP, SEL_NONE, 2'h0);
            t(CRM_DCLINV, OPC_TEST, K_NOP, SEL_NONE, 2'h0);
            t(CRM_IPREF, OPC_ADDR, K_PREF, SEL_I, SC_ADDR);
        end
        // user and privileged flush and barriers, then a user refusal
        for (int q = 0; q < 2; q++) begin
            wr(CRM_ICACHE, OPC_SPECIAL, q[0]);
            chk("pf", 5'h05, res);
            wr(CRM_DCLEAN, OPC_SPECIAL, q[0]);
            chk("sync", q + 1, nsync);
            wr(CRM_DCLEAN, OPC_DMB, q[0]);
            chk("order", 5'h09, res);
        end
        wr(CRM_DCACHE, OPC_ALL, 1'b1);
        chk("undef", 5'h02, res);
        chk("nocmd", 32, ncmd);
        ABORT = 1'b1;
        t(CRM_IPREF, OPC_ADDR, K_NOP, SEL_NONE, 2'h0);
        sleep(IRQ_LINE);
        chk("exc", 5'h10, res);
        chk("link", OP_PC + RET_LINK_OFS, lnk);
        chk("fiq", 0, EXC_FIQ);
        IRQ_MASK = 1'b1;
        sleep(IRQ_LINE);
        chk("masked", 5'h01, res);
        DBG_EN = 1'b1;
        sleep(DBG_REQ);
        chk("debug", 5'h01, res);
        wrap_up;
    end
    // watchdog well beyond the few hundred cycles of the tests
    initial begin
        #120000;
        chk("timeout", 0, 1);
        wrap_up;
    end
endmodule
`default_nettype wire
